// [logic/cbl_exec.sv]
// execution unit for shift, bit/flag and data-transfer instructions
// Functional notes
// (RULE_01) rotate right through carry takes one cycle, old carry to bit 7, bit 0 to carry, Z C N V updated.
// (RULE_02) arithmetic right shift takes one cycle, bit 7 kept, bit 0 to carry, Z C N V updated.
// (RULE_03) a selected register bit is copied into T in one cycle and only T changes.
// (RULE_04) T is copied into a selected register bit in one cycle and no flag changes.
// (RULE_05) a one-cycle set instruction exists for each status flag and touches only that flag.
// (RULE_06) a one-cycle clear instruction exists for each status flag and touches only that flag.
// (RULE_07) load through X, Y or Z then pointer plus one, two cycles, flags untouched.
// (RULE_08) pointer minus one first then load from the new address, two cycles, flags untouched.
// (RULE_09) load from Y or Z plus displacement, pointer unchanged, two cycles.
// (RULE_10) load from an address carried in the instruction, two cycles, flags untouched.
// (RULE_11) store through X, Y or Z then pointer plus one, two cycles, flags untouched.
// (RULE_12) pointer minus one first then store to the new address, two cycles, flags untouched.
// (RULE_13) move, pair copy and immediate load take one cycle and leave all flags alone.
// (RULE_14) shift results set Z and N from the final 8-bit result.
`timescale 1ns/100ps
`include "cbl_map.svh"
module cbl_exec
    import cbl_pkg::*;
(
    input wire logic clock, // 10 MHz core clock
    input wire logic reset, // synchronous, active high
    input wire logic instr_valid, // decoder offers an instruction
    input wire cbl_instr_t instr, // decoded instruction
    output logic instr_ready, // unit can take an instruction
    output cbl_mem_req_t mem_req, // data memory request
    input wire logic [`CBL_DATA_W-1:0] mem_rdata, // read data, same cycle as re
    output logic illegal, // pulse: refused instruction
    output logic [`CBL_DATA_W-1:0] status_flags_reg, // status flags
    input wire logic [`CBL_RIDX_W-1:0] peek_addr, // register to observe
    output logic [`CBL_DATA_W-1:0] peek_data // registered peek value
);
    typedef enum logic {ST_IDLE, ST_MEM} cbl_state_t;

    logic [`CBL_DATA_W-1:0] regs [`CBL_NREGS];
    logic [`CBL_DATA_W-1:0] next_regs [`CBL_NREGS];
    logic [`CBL_DATA_W-1:0] next_status_flags_reg, next_peek;
    cbl_state_t state, next_state;
    cbl_mem_req_t next_mem;
    logic next_illegal;
    logic pend_load, next_pend_load;
    logic pend_ptr_wr, next_pend_ptr_wr;
    logic [`CBL_RIDX_W-1:0] pend_dst, next_pend_dst, pend_ptr, next_pend_ptr;
    logic [`CBL_ADDR_W-1:0] pend_ptr_val, next_pend_ptr_val;
    logic accept;
    logic [`CBL_RIDX_W-1:0] ptr_lo;
    logic [`CBL_ADDR_W-1:0] ptr_val;
    logic [`CBL_DATA_W-1:0] dst_val, src_val, sh_res;
    logic sh_c, sh_z, sh_n, sh_v;
    logic [`CBL_DATA_W-1:0] regs_status_flags_reg;

    // ==========================================================
    // helpers
    function automatic logic [`CBL_RIDX_W-1:0] ptr_base(input cbl_ptr_t sel);
        case (sel)
            PTR_X: ptr_base = `CBL_PTR_X_LO;
            PTR_Y: ptr_base = `CBL_PTR_Y_LO;
            default: ptr_base = `CBL_PTR_Z_LO;
        endcase
    endfunction

    function automatic logic is_one_cycle(input cbl_op_t op);
        is_one_cycle = !(op inside {OP_LOAD_INDIRECT, OP_STORE_INDIRECT,
                                    OP_LOAD_DISPLACED, OP_LOAD_DIRECT});
    endfunction

    // ready only between transfers; memory ops hold the unit for a second cycle
    assign instr_ready = (state == ST_IDLE);
    assign accept = instr_valid && instr_ready;
    assign ptr_lo = ptr_base(instr.ptr_sel);
    assign ptr_val = {regs[ptr_lo + 5'h01], regs[ptr_lo]};
    assign dst_val = regs[instr.dst];
    assign src_val = regs[instr.src];
    assign status_flags_reg = regs_status_flags_reg;

    cbl_shift_unit u_shift (
        .value(dst_val),
        .carry_in(regs_status_flags_reg[`CBL_FLAG_C]),
        .is_asr(instr.op == OP_ARITH_SHIFT_RIGHT),
        .result(sh_res),
        .c_out(sh_c),
        .z_out(sh_z),
        .n_out(sh_n),
        .v_out(sh_v)
    );

    // ==========================================================
    // next state of registers, flags and memory strobes
    always_comb begin
        next_regs = regs;
        next_status_flags_reg = regs_status_flags_reg;
        next_state = state;
        next_mem = mem_req;
        next_mem.we = 1'b0;
        next_mem.re = 1'b0;
        next_illegal = 1'b0;
        next_pend_load = pend_load;
        next_pend_ptr_wr = pend_ptr_wr;
        next_pend_dst = pend_dst;
        next_pend_ptr = pend_ptr;
        next_pend_ptr_val = pend_ptr_val;
        next_peek = regs[peek_addr];
        if (state == ST_MEM) begin
            // pointer first so a load into a pointer register keeps the loaded byte
            if (pend_ptr_wr) begin
                next_regs[pend_ptr] = pend_ptr_val[`CBL_DATA_W-1:0]; // RULE_07
                next_regs[pend_ptr + 5'h01] = pend_ptr_val[`CBL_ADDR_W-1:`CBL_DATA_W]; // RULE_12
            end
            if (pend_load) begin
                next_regs[pend_dst] = mem_rdata; // RULE_10
            end
            next_state = ST_IDLE;
        end else if (accept) begin
            next_pend_dst = instr.dst;
            next_pend_ptr = ptr_lo;
            next_pend_ptr_wr = 1'b0;
            next_pend_load = 1'b0;
            next_mem.wdata = src_val;
            case (instr.op)
                OP_ROTATE_RIGHT_VIA_CARRY, OP_ARITH_SHIFT_RIGHT: begin
                    next_regs[instr.dst] = sh_res; // RULE_01 RULE_02
                    next_status_flags_reg[`CBL_FLAG_C] = sh_c;
                    next_status_flags_reg[`CBL_FLAG_Z] = sh_z; // RULE_14
                    next_status_flags_reg[`CBL_FLAG_N] = sh_n; // RULE_14
                    next_status_flags_reg[`CBL_FLAG_V] = sh_v;
                end
                OP_BIT_TO_TRANSFER_FLAG: next_status_flags_reg[`CBL_FLAG_T] = src_val[instr.bit_sel]; // RULE_03
                OP_TRANSFER_FLAG_TO_BIT: begin
                    next_regs[instr.dst][instr.bit_sel] = regs_status_flags_reg[`CBL_FLAG_T]; // RULE_04
                end
                OP_FLAG_SET: next_status_flags_reg[instr.bit_sel] = 1'b1; // RULE_05
                OP_FLAG_CLEAR: next_status_flags_reg[instr.bit_sel] = 1'b0; // RULE_06
                OP_MOVE: next_regs[instr.dst] = src_val; // RULE_13
                OP_COPY_REGISTER_PAIR: begin
                    // pair copy uses even indices; the low bit of each index is ignored
                    next_regs[{instr.dst[4:1], 1'b0}] = regs[{instr.src[4:1], 1'b0}]; // RULE_13
                    next_regs[{instr.dst[4:1], 1'b1}] = regs[{instr.src[4:1], 1'b1}]; // RULE_13
                end
                OP_LOAD_IMMEDIATE: next_regs[instr.dst] = instr.imm; // RULE_13
                OP_LOAD_INDIRECT, OP_STORE_INDIRECT: begin
                    next_state = ST_MEM;
                    next_pend_load = (instr.op == OP_LOAD_INDIRECT);
                    next_mem.re = (instr.op == OP_LOAD_INDIRECT);
                    next_mem.we = (instr.op == OP_STORE_INDIRECT);
                    case (instr.amode)
                        AM_POST_INC: begin
                            next_mem.addr = ptr_val; // RULE_07 RULE_11
                            next_pend_ptr_wr = 1'b1;
                            next_pend_ptr_val = ptr_val + `CBL_PTR_STEP; // RULE_11
                        end
                        AM_PRE_DEC: begin
                            next_mem.addr = ptr_val - `CBL_PTR_STEP; // RULE_08 RULE_12
                            next_pend_ptr_wr = 1'b1;
                            next_pend_ptr_val = ptr_val - `CBL_PTR_STEP; // RULE_08
                        end
                        default: next_mem.addr = ptr_val;
                    endcase
                end
                OP_LOAD_DISPLACED: begin
                    // there is no displacement form through X: refuse it
                    if (instr.ptr_sel == PTR_X) begin
                        next_illegal = 1'b1;
                    end else begin
                        next_state = ST_MEM;
                        next_pend_load = 1'b1;
                        next_mem.re = 1'b1;
                        next_mem.addr = ptr_val + {{(`CBL_ADDR_W-`CBL_DISP_W){1'b0}},
                                                   instr.disp}; // RULE_09
                    end
                end
                OP_LOAD_DIRECT: begin
                    next_state = ST_MEM;
                    next_pend_load = 1'b1;
                    next_mem.re = 1'b1;
                    next_mem.addr = instr.addr; // RULE_10
                end
                default: next_illegal = 1'b1;
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clock) begin
        if (reset) begin
            for (int i = 0; i < `CBL_NREGS; i++) begin
                regs[i] <= `CBL_REG_RESET;
            end
            regs_status_flags_reg <= `CBL_STATUS_FLAGS_REG_RESET;
            state <= ST_IDLE;
            mem_req <= '{addr: `CBL_ADDR_RESET, wdata: `CBL_REG_RESET, we: 1'b0, re: 1'b0};
            illegal <= 1'b0;
            pend_load <= 1'b0;
            pend_ptr_wr <= 1'b0;
            pend_dst <= '0;
            pend_ptr <= '0;
            pend_ptr_val <= `CBL_ADDR_RESET;
            peek_data <= `CBL_REG_RESET;
        end else begin
            regs <= next_regs;
            regs_status_flags_reg <= next_status_flags_reg;
            state <= next_state;
            mem_req <= next_mem;
            illegal <= next_illegal;
            pend_load <= next_pend_load;
            pend_ptr_wr <= next_pend_ptr_wr;
            pend_dst <= next_pend_dst;
            pend_ptr <= next_pend_ptr;
            pend_ptr_val <= next_pend_ptr_val;
            peek_data <= next_peek;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence seq_mem_issue;
        accept && !is_one_cycle(instr.op) && !next_illegal;
    endsequence
    sequence seq_mem_cycle;
        state == ST_MEM && !instr_ready && (mem_req.we ^ mem_req.re);
    endsequence

    AST_ROR_RESULT: assert property (accept && instr.op == OP_ROTATE_RIGHT_VIA_CARRY |=> // RULE_01
        regs[$past(instr.dst)] == {$past(regs_status_flags_reg[`CBL_FLAG_C]), $past(dst_val[7:1])}
        && regs_status_flags_reg[`CBL_FLAG_C] == $past(dst_val[0]))
        else $error("rotate result or carry wrong");
    AST_ASR_RESULT: assert property (accept && instr.op == OP_ARITH_SHIFT_RIGHT |=> // RULE_02
        regs[$past(instr.dst)] == {$past(dst_val[7]), $past(dst_val[7:1])}
        && regs_status_flags_reg[`CBL_FLAG_V] == (regs_status_flags_reg[`CBL_FLAG_N] ^ regs_status_flags_reg[`CBL_FLAG_C]))
        else $error("arithmetic shift result wrong");
    AST_SHIFT_ZN: assert property (accept && (instr.op inside {OP_ROTATE_RIGHT_VIA_CARRY, // RULE_14
        OP_ARITH_SHIFT_RIGHT}) |=> regs_status_flags_reg[`CBL_FLAG_Z] == (regs[$past(instr.dst)] == 8'h00)
        && regs_status_flags_reg[`CBL_FLAG_N] == regs[$past(instr.dst)][7])
        else $error("shift zero or negative flag wrong");
    AST_BST_T: assert property (accept && instr.op == OP_BIT_TO_TRANSFER_FLAG |=> // RULE_03
        regs_status_flags_reg[`CBL_FLAG_T] == $past(src_val[instr.bit_sel])
        && (regs_status_flags_reg & 8'hbf) == ($past(regs_status_flags_reg) & 8'hbf))
        else $error("bit to transfer flag wrong");
    AST_BLD_BIT: assert property (accept && instr.op == OP_TRANSFER_FLAG_TO_BIT |=> // RULE_04
        regs[$past(instr.dst)][$past(instr.bit_sel)] == $past(regs_status_flags_reg[`CBL_FLAG_T])
        && $stable(regs_status_flags_reg))
        else $error("transfer flag to bit wrong");
    AST_FLAG_SET: assert property (accept && instr.op == OP_FLAG_SET |=> // RULE_05
        regs_status_flags_reg == ($past(regs_status_flags_reg) | (8'h01 << $past(instr.bit_sel))))
        else $error("flag set touched other flags");
    AST_FLAG_CLEAR: assert property (accept && instr.op == OP_FLAG_CLEAR |=> // RULE_06
        regs_status_flags_reg == ($past(regs_status_flags_reg) & ~(8'h01 << $past(instr.bit_sel))))
        else $error("flag clear touched other flags");
    AST_MOVE_FLAGS: assert property (accept && (instr.op inside {OP_MOVE, // RULE_13
        OP_COPY_REGISTER_PAIR, OP_LOAD_IMMEDIATE}) |=> $stable(regs_status_flags_reg) && instr_ready)
        else $error("move changed flags or took two cycles");
    AST_MEM_TWO_CYCLE: assert property (seq_mem_issue |=> seq_mem_cycle ##1 // RULE_10
        instr_ready && $stable(regs_status_flags_reg))
        else $error("memory transfer not two cycles");
    AST_LOAD_DATA: assert property (state == ST_MEM && pend_load |=> // RULE_09
        regs[$past(pend_dst)] == $past(mem_rdata))
        else $error("loaded byte not written");
    AST_POST_INC: assert property (accept && (instr.op inside {OP_LOAD_INDIRECT, // RULE_07
        OP_STORE_INDIRECT}) && instr.amode == AM_POST_INC |=> mem_req.addr == $past(ptr_val)
        ##1 {regs[$past(ptr_lo, 2) + 5'h01], regs[$past(ptr_lo, 2)]} ==
        $past(mem_req.addr) + 16'h0001 || $past(pend_load && pend_dst[4:1] == pend_ptr[4:1]))
        else $error("post increment wrong");
    AST_PRE_DEC: assert property (accept && (instr.op inside {OP_LOAD_INDIRECT, // RULE_08
        OP_STORE_INDIRECT}) && instr.amode == AM_PRE_DEC |=> // RULE_12
        mem_req.addr == $past(ptr_val) - 16'h0001 && pend_ptr_val == mem_req.addr)
        else $error("pre decrement wrong");
    AST_STORE_DATA: assert property (accept && instr.op == OP_STORE_INDIRECT |=> // RULE_11
        mem_req.we && !mem_req.re && mem_req.wdata == $past(src_val))
        else $error("store strobe or data wrong");
endmodule // cbl_exec

// [logic/cbl_map.svh]
// named constants for the bit, flag and load/store execution block
`ifndef CBL_MAP_SVH
`define CBL_MAP_SVH
// ==========================================================
// widths
`define CBL_DATA_W 8
`define CBL_ADDR_W 16
`define CBL_RIDX_W 5
`define CBL_NREGS 32
`define CBL_DISP_W 6
// ==========================================================
// status flag positions
`define CBL_FLAG_C 3'h0
`define CBL_FLAG_Z 3'h1
`define CBL_FLAG_N 3'h2
`define CBL_FLAG_V 3'h3
`define CBL_FLAG_S 3'h4
`define CBL_FLAG_H 3'h5
`define CBL_FLAG_T 3'h6
`define CBL_FLAG_I 3'h7
// ==========================================================
// pointer pairs, low byte register index
`define CBL_PTR_X_LO 5'h1a
`define CBL_PTR_Y_LO 5'h1c
`define CBL_PTR_Z_LO 5'h1e
`define CBL_PTR_STEP 16'h0001
// ==========================================================
// reset values
`define CBL_STATUS_FLAGS_REG_RESET 8'h00
`define CBL_REG_RESET 8'h00
`define CBL_ADDR_RESET 16'h0000
`endif

// [logic/cbl_pkg.sv]
// types shared by the bit, flag and load/store execution block
package cbl_pkg;
`include "cbl_map.svh"
    // ==========================================================
    // operations
    typedef enum logic [3:0] {
        OP_ROTATE_RIGHT_VIA_CARRY,
        OP_ARITH_SHIFT_RIGHT,
        OP_BIT_TO_TRANSFER_FLAG,
        OP_TRANSFER_FLAG_TO_BIT,
        OP_FLAG_SET,
        OP_FLAG_CLEAR,
        OP_MOVE,
        OP_COPY_REGISTER_PAIR,
        OP_LOAD_IMMEDIATE,
        OP_LOAD_INDIRECT,
        OP_STORE_INDIRECT,
        OP_LOAD_DISPLACED,
        OP_LOAD_DIRECT
    } cbl_op_t;
    typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} cbl_ptr_t;
    typedef enum logic [1:0] {AM_PLAIN, AM_POST_INC, AM_PRE_DEC} cbl_amode_t;
    // ==========================================================
    // decoded instruction from the decoder
    typedef struct packed {
        cbl_op_t op;
        logic [`CBL_RIDX_W-1:0] dst;
        logic [`CBL_RIDX_W-1:0] src;
        logic [2:0] bit_sel;
        logic [`CBL_DATA_W-1:0] imm;
        cbl_ptr_t ptr_sel;
        cbl_amode_t amode;
        logic [`CBL_DISP_W-1:0] disp;
        logic [`CBL_ADDR_W-1:0] addr;
    } cbl_instr_t;
    // data memory request
    typedef struct packed {
        logic [`CBL_ADDR_W-1:0] addr;
        logic [`CBL_DATA_W-1:0] wdata;
        logic we;
        logic re;
    } cbl_mem_req_t;
endpackage

// [logic/cbl_shift_unit.sv]
// rotate-through-carry and arithmetic right shift with flag results
`timescale 1ns/100ps
`include "cbl_map.svh"
module cbl_shift_unit
    import cbl_pkg::*;
(
    input wire logic [`CBL_DATA_W-1:0] value, // operand
    input wire logic carry_in, // current carry flag
    input wire logic is_asr, // 1 arithmetic shift, 0 rotate
    output logic [`CBL_DATA_W-1:0] result, // shifted value
    output logic c_out, // new carry
    output logic z_out, // new zero
    output logic n_out, // new negative
    output logic v_out // new overflow
);
    // ==========================================================
    // shift and flags
    always_comb begin
        if (is_asr) begin
            result = {value[`CBL_DATA_W-1], value[`CBL_DATA_W-1:1]}; // RULE_02
        end else begin
            result = {carry_in, value[`CBL_DATA_W-1:1]}; // RULE_01
        end
        c_out = value[0];
        // flags taken from the finished result, not the operand
        z_out = (result == '0); // RULE_14
        n_out = result[`CBL_DATA_W-1]; // RULE_14
        v_out = n_out ^ c_out;
    end
endmodule // cbl_shift_unit

// [tb/tb_top.sv]
// self-checking testbench for the bit, flag and load/store execution unit
`timescale 1ns/100ps
`include "cbl_map.svh"
module tb_top
    import cbl_pkg::*;
;
    // ==========================================================
    // clock, reset and design connections
    logic clock;
    logic reset;
    logic instr_valid;
    cbl_instr_t instr;
    logic instr_ready;
    cbl_mem_req_t mem_req;
    logic [7:0] mem_rdata;
    logic illegal;
    logic [7:0] status_flags_reg;
    logic [4:0] peek_addr;
    logic [7:0] peek_data;
    int error_cnt = 0;
    int total_checks = 0;
    // expectations for the next instruction, set by the tests
    cbl_instr_t ins;
    logic [7:0] exp_sr = 8'h00;
    logic e_re = 1'b0;
    logic e_we = 1'b0;
    logic e_ill = 1'b0;
    logic [15:0] e_addr = 16'h0000;
    logic [7:0] e_wdata = 8'h00;

    always #50 clock = ~clock;

    // memory stand-in: data is the low address byte xor 3c, inverted when not read
    // so a stale or early capture cannot match by accident
    assign mem_rdata = mem_req.re ? (mem_req.addr[7:0] ^ 8'h3c) : ~(mem_req.addr[7:0] ^ 8'h3c);

    cbl_exec DUT (
        .clock(clock),
        .reset(reset),
        .instr_valid(instr_valid),
        .instr(instr),
        .instr_ready(instr_ready),
        .mem_req(mem_req),
        .mem_rdata(mem_rdata),
        .illegal(illegal),
        .status_flags_reg(status_flags_reg),
        .peek_addr(peek_addr),
        .peek_data(peek_data)
    );

    // ==========================================================
    // checking and access tasks
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // offer ins for one edge, then check cycle 1 (and cycle 2 for memory ops)
    task automatic go(input bit two);
        @(negedge clock);
        instr = ins;
        instr_valid = 1'b1;
        @(negedge clock);
        instr_valid = 1'b0;
        chk("ready_c1", {15'h0000, ~two}, {15'h0000, instr_ready});
        chk("status", {8'h00, exp_sr}, {8'h00, status_flags_reg});
        chk("illegal", {15'h0000, e_ill}, {15'h0000, illegal});
        chk("mem_re", {15'h0000, e_re}, {15'h0000, mem_req.re});
        chk("mem_we", {15'h0000, e_we}, {15'h0000, mem_req.we});
        if (e_re || e_we) begin
            chk("mem_addr", e_addr, mem_req.addr);
        end
        if (e_we) begin
            chk("mem_wdata", {8'h00, e_wdata}, {8'h00, mem_req.wdata});
        end
        if (two) begin
            @(negedge clock);
            chk("ready_c2", 16'h0001, {15'h0000, instr_ready});
        end
        e_re = 1'b0;
        e_we = 1'b0;
        e_ill = 1'b0;
    endtask

    // peek shows the register one edge after the index is applied
    task automatic pk(input logic [4:0] idx, input logic [7:0] e);
        @(negedge clock);
        peek_addr = idx;
        @(negedge clock);
        chk($sformatf("r%0d", idx), {8'h00, e}, {8'h00, peek_data});
    endtask

    task automatic op1(input cbl_op_t op, input logic [4:0] d, input logic [4:0] s,
                       input logic [2:0] b, input logic [7:0] k);
        ins = '0;
        ins.op = op;
        ins.dst = d;
        ins.src = s;
        ins.bit_sel = b;
        ins.imm = k;
        go(1'b0);
    endtask

    task automatic mem(input cbl_op_t op, input logic [4:0] r, input cbl_ptr_t p,
                       input cbl_amode_t am, input logic [5:0] q, input logic [15:0] a);
        ins = '0;
        ins.op = op;
        ins.dst = r;
        ins.src = r;
        ins.ptr_sel = p;
        ins.amode = am;
        ins.disp = q;
        ins.addr = a;
        go(1'b1);
    endtask

    // ==========================================================
    // watchdog: the tests need well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clock);
        $display("Error watchdog expected completion seen timeout");
        error_cnt++;
        tally_and_finish();
    end

    // ==========================================================
    // main sequence
    initial begin
        clock = 1'b0;
        reset = 1'b1;
        instr_valid = 1'b0;
        instr = '0;
        ins = '0;
        peek_addr = 5'h00;
        repeat (3) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        chk("reset_status", 16'h0000, {8'h00, status_flags_reg});
        chk("reset_ready", 16'h0001, {15'h0000, instr_ready});
        // every flag set, then cleared, each alone
        for (int i = 0; i < 8; i++) begin
            exp_sr[i] = 1'b1;
            op1(OP_FLAG_SET, 5'h00, 5'h00, i[2:0], 8'h00);
        end
        for (int i = 0; i < 8; i++) begin
            exp_sr[i] = 1'b0;
            op1(OP_FLAG_CLEAR, 5'h00, 5'h00, i[2:0], 8'h00);
        end
        $display("test flag set and clear done");
        // moves leave flags alone; S set first to spot stray flag writes
        exp_sr[`CBL_FLAG_S] = 1'b1;
        op1(OP_FLAG_SET, 5'h00, 5'h00, `CBL_FLAG_S, 8'h00);
        op1(OP_LOAD_IMMEDIATE, 5'h10, 5'h00, 3'h0, 8'h81);
        op1(OP_LOAD_IMMEDIATE, 5'h11, 5'h00, 3'h0, 8'h7e);
        op1(OP_MOVE, 5'h14, 5'h10, 3'h0, 8'h00);
        op1(OP_COPY_REGISTER_PAIR, 5'h16, 5'h10, 3'h0, 8'h00);
        pk(5'h14, 8'h81);
        pk(5'h16, 8'h81);
        pk(5'h17, 8'h7e);
        $display("test moves done");
        // rotate and shift, S must survive (V = N xor C)
        exp_sr[`CBL_FLAG_C] = 1'b1;
        op1(OP_FLAG_SET, 5'h00, 5'h00, `CBL_FLAG_C, 8'h00);
        exp_sr[3:0] = 4'b0101;
        op1(OP_ROTATE_RIGHT_VIA_CARRY, 5'h10, 5'h10, 3'h0, 8'h00);
        pk(5'h10, 8'hc0);
        op1(OP_LOAD_IMMEDIATE, 5'h12, 5'h00, 3'h0, 8'h01);
        exp_sr[3:0] = 4'b0100;
        exp_sr[`CBL_FLAG_C] = 1'b0;
        op1(OP_FLAG_CLEAR, 5'h00, 5'h00, `CBL_FLAG_C, 8'h00);
        exp_sr[3:0] = 4'b1011;
        op1(OP_ROTATE_RIGHT_VIA_CARRY, 5'h12, 5'h12, 3'h0, 8'h00);
        pk(5'h12, 8'h00);
        exp_sr[3:0] = 4'b1100;
        op1(OP_ARITH_SHIFT_RIGHT, 5'h10, 5'h10, 3'h0, 8'h00);
        pk(5'h10, 8'he0);
        exp_sr[3:0] = 4'b0000;
        op1(OP_ARITH_SHIFT_RIGHT, 5'h11, 5'h11, 3'h0, 8'h00);
        pk(5'h11, 8'h3f);
        $display("test shifts done");
        // bit to T and back
        exp_sr[`CBL_FLAG_T] = 1'b1;
        op1(OP_BIT_TO_TRANSFER_FLAG, 5'h00, 5'h10, 3'h5, 8'h00);
        op1(OP_TRANSFER_FLAG_TO_BIT, 5'h12, 5'h12, 3'h3, 8'h00);
        pk(5'h12, 8'h08);
        exp_sr[`CBL_FLAG_T] = 1'b0;
        op1(OP_BIT_TO_TRANSFER_FLAG, 5'h00, 5'h12, 3'h0, 8'h00);
        $display("test bit transfer done");
        // loads; pointers set up with immediate loads
        op1(OP_LOAD_IMMEDIATE, 5'h1e, 5'h00, 3'h0, 8'h10);
        op1(OP_LOAD_IMMEDIATE, 5'h1f, 5'h00, 3'h0, 8'h00);
        op1(OP_LOAD_IMMEDIATE, 5'h1a, 5'h00, 3'h0, 8'h00);
        op1(OP_LOAD_IMMEDIATE, 5'h1b, 5'h00, 3'h0, 8'h01);
        op1(OP_LOAD_IMMEDIATE, 5'h1c, 5'h00, 3'h0, 8'h40);
        op1(OP_LOAD_IMMEDIATE, 5'h1d, 5'h00, 3'h0, 8'h00);
        e_re = 1'b1;
        e_addr = 16'h0010;
        mem(OP_LOAD_INDIRECT, 5'h01, PTR_Z, AM_POST_INC, 6'h00, 16'h0000);
        pk(5'h01, 8'h2c);
        pk(5'h1e, 8'h11);
        // pre-decrement across a byte boundary of the pointer
        e_re = 1'b1;
        e_addr = 16'h00ff;
        mem(OP_LOAD_INDIRECT, 5'h02, PTR_X, AM_PRE_DEC, 6'h00, 16'h0000);
        pk(5'h02, 8'hc3);
        pk(5'h1a, 8'hff);
        pk(5'h1b, 8'h00);
        // plain load through X leaves the pointer where it was
        e_re = 1'b1;
        e_addr = 16'h00ff;
        mem(OP_LOAD_INDIRECT, 5'h06, PTR_X, AM_PLAIN, 6'h00, 16'h0000);
        pk(5'h06, 8'hc3);
        pk(5'h1a, 8'hff);
        // largest displacement, pointer kept
        e_re = 1'b1;
        e_addr = 16'h007f;
        mem(OP_LOAD_DISPLACED, 5'h03, PTR_Y, AM_PLAIN, 6'h3f, 16'h0000);
        pk(5'h03, 8'h43);
        pk(5'h1c, 8'h40);
        // displacement through X is refused, unit stays ready
        e_ill = 1'b1;
        ins = '0;
        ins.op = OP_LOAD_DISPLACED;
        ins.dst = 5'h05;
        ins.ptr_sel = PTR_X;
        ins.disp = 6'h01;
        go(1'b0);
        pk(5'h05, 8'h00);
        e_re = 1'b1;
        e_addr = 16'h1234;
        mem(OP_LOAD_DIRECT, 5'h04, PTR_X, AM_PLAIN, 6'h00, 16'h1234);
        pk(5'h04, 8'h08);
        $display("test loads done");
        // stores: post-increment through Y, pre-decrement through Z
        e_we = 1'b1;
        e_addr = 16'h0040;
        e_wdata = 8'he0;
        mem(OP_STORE_INDIRECT, 5'h10, PTR_Y, AM_POST_INC, 6'h00, 16'h0000);
        pk(5'h1c, 8'h41);
        e_we = 1'b1;
        e_addr = 16'h0010;
        e_wdata = 8'h3f;
        mem(OP_STORE_INDIRECT, 5'h11, PTR_Z, AM_PRE_DEC, 6'h00, 16'h0000);
        pk(5'h1e, 8'h10);
        pk(5'h1f, 8'h00);
        $display("test stores done");
        tally_and_finish();
    end
endmodule // tb_top
